//--- rtl/refill_params.svh
// Constants for the primary cache refill engine
`ifndef REFILL_PARAMS_SVH
`define REFILL_PARAMS_SVH
`define QW_W 128
`define ADDR_W 32
`define DLINE_LAST 2'h1
`define ILINE_LAST 2'h3
`define SLOT_N 4
`define WAIT_N 16
`define LAT_M1 4'h6
`define LAT_M15 4'h8
`define LAT_M2 4'h9
`define HALF_M1 3'h2
`define HALF_M15 3'h3
`define HALF_M2 3'h4
`define CRED_MAX 3'h4
`define CRED_STEP 3'h2
`define BURST_MAX 3'h3
`define BANK_BIT 5
`define QW_LSB 4
`endif

//--- rtl/refill_pkg.sv
// Types shared by the refill engine and its leaf modules
`include "refill_params.svh"
package refill_pkg;
    typedef enum logic [1:0] {
        MODE_1 = 2'h0, MODE_1P5 = 2'h1, MODE_2 = 2'h2
    } mode_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0, ST_WAIT = 2'h1, ST_FILL = 2'h3, ST_GAP = 2'h2
    } state_t;
    typedef enum logic [2:0] {
        OWN_NONE, OWN_EXT, OWN_TC, OWN_AC, OWN_LD, OWN_ST
    } own_t;
    typedef struct packed {
        logic vld;
        logic bank;
    } areq_t;
    typedef struct packed {
        logic [`ADDR_W-1:0] addr;
        logic icache;
    } miss_t;
    typedef struct packed {
        miss_t m;
        logic [1:0] slot;
    } lreq_t;
    typedef struct packed {
        logic [1:0] slot;
        logic [1:0] idx;
        logic last;
        logic [`QW_W-1:0] data;
    } beat_t;
    typedef struct packed {
        miss_t m;
        logic [1:0] idx;
        logic [`QW_W-1:0] data;
    } fill_t;
endpackage

//--- rtl/sync_2ff.sv
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module sync_2ff #(parameter int W = 1) (
    // Destination clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Level in and synchronised level out
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_r;
    // First stage is read only by the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= '0;
            q_o <= '0;
        end else begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end
endmodule // sync_2ff

//--- rtl/miss_slot.sv
// One outstanding-miss slot of the external interface
`timescale 1ns/1ps
module miss_slot import refill_pkg::*; (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // Control
    input wire logic alloc_i,
    input wire logic issue_i,
    input wire logic rel_i,
    input wire miss_t info_i,
    // State
    output logic busy_o,
    output logic issued_o,
    output miss_t info_o
);
    // Release beats allocation; engine never does both at once
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            busy_o <= 1'b0;
            issued_o <= 1'b0;
        end else if (rel_i) begin
            busy_o <= 1'b0;
            issued_o <= 1'b0;
        end else if (alloc_i) begin
            busy_o <= 1'b1;
            issued_o <= 1'b0;
        end else if (issue_i) begin
            issued_o <= 1'b1;
        end
    end
    // Miss address kept for the whole refill
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            info_o <= '0;
        end else if (alloc_i) begin
            info_o <= info_i;
        end
    end
endmodule // miss_slot

//--- rtl/primary_cache_refill_engine.sv
// Primary cache refill engine with secondary cache link domain
`timescale 1ns/1ps
`include "refill_params.svh"
module primary_cache_refill_engine import refill_pkg::*; (
    // Core clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // Link clock
    input wire logic sc_clk_i,
    // Configuration
    input wire mode_t secondary_clock_divisor_mode_i,
    // Miss requests
    input wire logic miss_vld_i,
    input wire miss_t miss_i,
    input wire logic miss_ld_i,
    input wire logic [3:0] miss_ld_id_i,
    output logic miss_rdy_o,
    // Load aborts
    input wire logic abort_i,
    input wire logic [3:0] abort_id_i,
    // Array requesters
    input wire areq_t ac_req_i,
    input wire areq_t tc_req_i,
    input wire areq_t ld_req_i,
    input wire areq_t st_req_i,
    input wire areq_t ext_probe_i,
    output own_t tag_own_o [2],
    output own_t data_own_o [2],
    // Primary cache fill port
    output logic fill_we_o,
    output fill_t fill_o,
    // Load forwarding
    output logic fwd_vld_o,
    output logic [`WAIT_N-1:0] fwd_mask_o,
    output logic [`QW_W-1:0] fwd_data_o,
    // Secondary cache link
    output logic sc_rd_o,
    output miss_t sc_req_o,
    output logic sc_rdy_o,
    input wire logic sc_vld_i,
    input wire logic [`QW_W-1:0] sc_data_i
);
    // Link domain state
    logic lrst;
    logic lreq_sync;
    logic lreq_seen_r;
    lreq_t lreq_r;
    logic [1:0] lcnt_r;
    beat_t beat_r;
    logic beat_tgl_r;
    logic ack_sync;
    logic ack_seen_r;
    logic llast;
    // Core domain state
    logic req_tgl_r;
    lreq_t req_word_r;
    logic beat_sync;
    logic beat_seen_r;
    logic ack_tgl_r;
    state_t state_r;
    logic [3:0] lat_r;
    logic [2:0] cred_r;
    logic [2:0] cred_nxt;
    logic [2:0] run_r;
    logic [3:0] lat_min;
    logic [2:0] halves;
    logic beat_new;
    logic take;
    logic pend;
    logic [1:0] pend_sel;
    logic [1:0] free_sel;
    logic [`SLOT_N-1:0] busy_v;
    logic [`SLOT_N-1:0] issued_v;
    logic [`SLOT_N-1:0] alloc_oh;
    logic [`SLOT_N-1:0] issue_oh;
    logic [`SLOT_N-1:0] rel_oh;
    logic [`SLOT_N-1:0] busy_nxt;
    miss_t info_v [`SLOT_N];
    miss_t beat_info;
    logic do_alloc;
    logic do_issue;
    logic fbank;
    logic [`WAIT_N-1:0] wt_vld_r;
    logic [1:0] wt_slot_r [`WAIT_N];
    logic [1:0] wt_qw_r [`WAIT_N];
    logic [`WAIT_N-1:0] hit;
    logic [1:0] miss_qw;

    // Reset and handshake toggles enter the link domain
    sync_2ff #(.W(1)) u_lrst (
        .clk_i(sc_clk_i), .rst_i(1'b0), .d_i(sys_rst_i), .q_o(lrst));
    sync_2ff #(.W(2)) u_lsync (
        .clk_i(sc_clk_i), .rst_i(lrst), .d_i({req_tgl_r, ack_tgl_r}),
        .q_o({lreq_sync, ack_sync}));
    // Beat toggle enters the core domain
    sync_2ff #(.W(1)) u_csync (
        .clk_i(core_clk_i), .rst_i(sys_rst_i), .d_i(beat_tgl_r),
        .q_o(beat_sync));

    // Link: latch a request word while its toggle is settled
    always_ff @(posedge sc_clk_i) begin
        if (lrst) begin
            lreq_seen_r <= 1'b0;
            lreq_r <= '0;
            sc_rd_o <= 1'b0;
            sc_req_o <= '0;
        end else begin
            sc_rd_o <= 1'b0;
            if (lreq_sync != lreq_seen_r) begin
                lreq_seen_r <= lreq_sync;
                lreq_r <= req_word_r;
                sc_rd_o <= 1'b1;
                sc_req_o <= req_word_r.m;
            end
        end
    end

    assign llast = lcnt_r ==
        (lreq_r.m.icache ? `ILINE_LAST : `DLINE_LAST);

    // Link: one beat held at a time; the core's ack reopens the link
    always_ff @(posedge sc_clk_i) begin
        if (lrst) begin
            lcnt_r <= 2'h0;
            sc_rdy_o <= 1'b0;
            beat_r <= '0;
            beat_tgl_r <= 1'b0;
            ack_seen_r <= 1'b0;
        end else if (lreq_sync != lreq_seen_r) begin
            lcnt_r <= 2'h0;
            sc_rdy_o <= 1'b1;
        end else if (sc_vld_i && sc_rdy_o) begin
            beat_r <= {lreq_r.slot, lcnt_r, llast, sc_data_i};
            beat_tgl_r <= ~beat_tgl_r;
            lcnt_r <= lcnt_r + 2'h1;
            sc_rdy_o <= 1'b0;
        end else if (ack_sync != ack_seen_r) begin
            ack_seen_r <= ack_sync;
            sc_rdy_o <= ~beat_r.last;
        end
    end

    // Latency floor and beat pacing per divisor mode
    always_comb begin
        case (secondary_clock_divisor_mode_i)
            MODE_1: begin
                lat_min = `LAT_M1;
                halves = `HALF_M1;
            end
            MODE_1P5: begin
                lat_min = `LAT_M15;
                halves = `HALF_M15;
            end
            default: begin
                lat_min = `LAT_M2;
                halves = `HALF_M2;
            end
        endcase
    end

    // Beat data is stable while its toggle differs from ours
    assign beat_new = beat_sync != beat_seen_r;
    assign take = beat_new && cred_r >= halves &&
        (state_r == ST_FILL || (state_r == ST_WAIT && lat_r >= lat_min));
    assign beat_info = info_v[beat_r.slot];
    assign fbank = beat_info.addr[`BANK_BIT];

    // Slot choice: first pending to issue, first free to allocate
    always_comb begin
        pend = 1'b0;
        pend_sel = 2'h0;
        free_sel = 2'h0;
        for (int i = `SLOT_N - 1; i >= 0; i--) begin
            if (busy_v[i] && !issued_v[i]) begin
                pend = 1'b1;
                pend_sel = i[1:0];
            end
            if (!busy_v[i]) begin
                free_sel = i[1:0];
            end
        end
    end

    assign do_alloc = miss_vld_i && miss_rdy_o;
    assign do_issue = state_r == ST_IDLE && pend;
    // Release only when the last beat is taken into the fill port
    assign rel_oh = (take && beat_r.last) ?
        (`SLOT_N'(1) << beat_r.slot) : '0;
    assign alloc_oh = do_alloc ? (`SLOT_N'(1) << free_sel) : '0;
    assign issue_oh = do_issue ? (`SLOT_N'(1) << pend_sel) : '0;
    assign busy_nxt = (busy_v | alloc_oh) & ~rel_oh;

    // Four slots of outstanding misses
    for (genvar s = 0; s < `SLOT_N; s++) begin : g_slot
        miss_slot u_slot (
            .core_clk_i(core_clk_i),
            .sys_rst_i(sys_rst_i),
            .alloc_i(alloc_oh[s]),
            .issue_i(issue_oh[s]),
            .rel_i(rel_oh[s]),
            .info_i(miss_i),
            .busy_o(busy_v[s]),
            .issued_o(issued_v[s]),
            .info_o(info_v[s]));
    end

    // Ready is registered from the occupancy after this cycle
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            miss_rdy_o <= 1'b0;
        end else begin
            miss_rdy_o <= ~&busy_nxt;
        end
    end

    // Refill sequencer
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            state_r <= ST_IDLE;
            run_r <= 3'h0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (pend) begin
                        state_r <= ST_WAIT;
                    end
                end
                ST_WAIT, ST_FILL: begin
                    if (take && beat_r.last) begin
                        // Long runs of misses get one bubble
                        if (pend && run_r >= `BURST_MAX) begin
                            state_r <= ST_GAP;
                            run_r <= 3'h0;
                        end else begin
                            state_r <= ST_IDLE;
                            run_r <= pend ? run_r + 3'h1 : 3'h0;
                        end
                    end else if (take) begin
                        state_r <= ST_FILL;
                    end
                end
                ST_GAP: begin
                    state_r <= ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Latency counter since the request left for the link
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            lat_r <= 4'h0;
        end else if (do_issue) begin
            lat_r <= 4'h1;
        end else if (state_r == ST_WAIT && lat_r != 4'hf) begin
            lat_r <= lat_r + 4'h1;
        end
    end

    // Half-clock credits give the fractional 1.5 mode rate
    always_comb begin
        cred_nxt = cred_r + `CRED_STEP - (take ? halves : 3'h0);
        if (cred_nxt > `CRED_MAX) begin
            cred_nxt = `CRED_MAX;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            cred_r <= `CRED_MAX;
        end else if (do_issue) begin
            cred_r <= `CRED_MAX;
        end else begin
            cred_r <= cred_nxt;
        end
    end

    // Request handshake toward the link, one line at a time
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            req_tgl_r <= 1'b0;
            req_word_r <= '0;
        end else if (do_issue) begin
            req_tgl_r <= ~req_tgl_r;
            req_word_r <= {info_v[pend_sel], pend_sel};
        end
    end

    // Acknowledge each taken beat so the link may send the next
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            beat_seen_r <= 1'b0;
            ack_tgl_r <= 1'b0;
        end else if (take) begin
            beat_seen_r <= beat_sync;
            ack_tgl_r <= ~ack_tgl_r;
        end
    end

    // Fill port: every beat is written, abort or not
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            fill_we_o <= 1'b0;
            fill_o <= '0;
        end else begin
            fill_we_o <= take;
            if (take) begin
                fill_o <= {beat_info, beat_r.idx, beat_r.data};
            end
        end
    end

    // Quadword of the line that the waiting load needs
    assign miss_qw = {miss_i.icache & miss_i.addr[`QW_LSB+1],
        miss_i.addr[`QW_LSB]};

    // Load waiters; a new wait wins over a same-cycle clear
    always_ff @(posedge core_clk_i) begin
        for (int i = 0; i < `WAIT_N; i++) begin
            if (sys_rst_i) begin
                wt_vld_r[i] <= 1'b0;
                wt_slot_r[i] <= 2'h0;
                wt_qw_r[i] <= 2'h0;
            end else if (do_alloc && miss_ld_i && miss_ld_id_i == i[3:0]) begin
                wt_vld_r[i] <= 1'b1;
                wt_slot_r[i] <= free_sel;
                wt_qw_r[i] <= miss_qw;
            end else if (hit[i] || (abort_i && abort_id_i == i[3:0])) begin
                wt_vld_r[i] <= 1'b0;
            end
        end
    end

    always_comb begin
        for (int i = 0; i < `WAIT_N; i++) begin
            hit[i] = take && wt_vld_r[i] && wt_slot_r[i] == beat_r.slot &&
                wt_qw_r[i] == beat_r.idx;
        end
    end

    // Words stream to waiting loads as they arrive
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            fwd_vld_o <= 1'b0;
            fwd_mask_o <= '0;
            fwd_data_o <= '0;
        end else begin
            fwd_vld_o <= |hit;
            fwd_mask_o <= hit;
            if (take) begin
                fwd_data_o <= beat_r.data;
            end
        end
    end

    // Per-bank array grants; external traffic always first
    for (genvar b = 0; b < 2; b++) begin : g_bank
        logic ext_b;
        assign ext_b = (take && !beat_info.icache && fbank == b) ||
            (ext_probe_i.vld && ext_probe_i.bank == b);
        always_ff @(posedge core_clk_i) begin
            if (sys_rst_i) begin
                tag_own_o[b] <= OWN_NONE;
                data_own_o[b] <= OWN_NONE;
            end else begin
                if (ext_b) begin
                    tag_own_o[b] <= OWN_EXT;
                end else if (tc_req_i.vld && tc_req_i.bank == b) begin
                    tag_own_o[b] <= OWN_TC;
                end else if (ac_req_i.vld && ac_req_i.bank == b) begin
                    tag_own_o[b] <= OWN_AC;
                end else begin
                    tag_own_o[b] <= OWN_NONE;
                end
                if (ext_b) begin
                    data_own_o[b] <= OWN_EXT;
                end else if (ld_req_i.vld && ld_req_i.bank == b) begin
                    data_own_o[b] <= OWN_LD;
                end else if (st_req_i.vld && st_req_i.bank == b) begin
                    data_own_o[b] <= OWN_ST;
                end else begin
                    data_own_o[b] <= OWN_NONE;
                end
            end
        end
    end

    // Checks on the core side
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    data_line_a: assert property (
        take && beat_r.last && !beat_info.icache |-> beat_r.idx == 2'h1)
        else $error("data line not two beats");
    inst_line_a: assert property (
        take && beat_r.last && beat_info.icache |-> beat_r.idx == 2'h3)
        else $error("instruction line not four beats");
    first_lat_a: assert property (
        take && state_r == ST_WAIT |-> lat_r >= lat_min)
        else $error("first beat too early");
    mode2_pace_a: assert property (
        take && secondary_clock_divisor_mode_i == MODE_2 |=> !take)
        else $error("mode 2 beats too close");
    gap_once_a: assert property (
        state_r == ST_GAP |=> state_r == ST_IDLE)
        else $error("idle gap longer than one cycle");
    fwd_word_a: assert property (
        |hit |=> fwd_vld_o && fwd_data_o == $past(beat_r.data))
        else $error("arriving word not forwarded");
    abort_keep_a: assert property (
        abort_i && busy_v[beat_r.slot] && take && !beat_r.last
        |=> busy_v[$past(beat_r.slot)])
        else $error("abort released a refill");
    full_stall_a: assert property (
        &busy_v && !(|rel_oh) |=> !miss_rdy_o)
        else $error("miss accepted with all slots busy");
    slot_rel_a: assert property (
        $fell(busy_v[0]) |-> $past(take && beat_r.last) ##1 1)
        else $error("slot freed before last beat");
    ext_wins_a: assert property (
        ext_probe_i.vld |=> tag_own_o[$past(ext_probe_i.bank)] == OWN_EXT)
        else $error("probe lost arbitration");
endmodule // primary_cache_refill_engine

//--- dv/sc_agent.sv
// Secondary cache model that returns one line per read request
`timescale 1ns/1ps
`include "refill_params.svh"
module sc_agent import refill_pkg::*; (
    // Link clock and bench control
    input wire logic sc_clk_i,
    input wire logic stall_i,
    // Read request from the engine
    input wire logic rd_i,
    input wire miss_t req_i,
    // Beat handshake
    input wire logic rdy_i,
    output logic vld_o = 1'b0,
    output logic [`QW_W-1:0] data_o = '0
);
    miss_t req_r = '0;
    logic act_r = 1'b0;
    logic [1:0] cnt_r = 2'h0;
    logic [1:0] lst;

    // Two beats for a data line, four for an instruction line
    assign lst = req_r.icache ? 2'h3 : 2'h1;

    // Beat counter; the line ends on its last accepted beat
    always @(posedge sc_clk_i) begin
        if (rd_i) begin
            req_r <= req_i;
            act_r <= 1'b1;
            cnt_r <= 2'h0;
        end else if (vld_o && rdy_i) begin
            cnt_r <= cnt_r + 2'h1;
            act_r <= cnt_r != lst;
        end
    end

    // An offered beat is held until taken; idle data keeps changing
    always @(posedge sc_clk_i) begin
        if (!vld_o || rdy_i) begin
            if (act_r && !stall_i && !(vld_o && cnt_r == lst)) begin
                vld_o <= 1'b1;
                data_o <= {req_r.addr, 94'h0, cnt_r + {1'b0, vld_o}};
            end else begin
                vld_o <= 1'b0;
                data_o <= ~data_o;
            end
        end
    end
endmodule // sc_agent

//--- dv/tb.sv
// Self-checking bench for the primary cache refill engine
`timescale 1ns/1ps
`include "refill_params.svh"
`define CHK(a, b) begin \
    compares++; \
    if ((a) !== (b)) begin \
        fail_count++; \
        $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); \
    end \
end
module tb import refill_pkg::*; ;
    logic core_clk_i = 1'b0;
    logic sc_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    mode_t md = MODE_1;
    logic miss_vld_i = 1'b0;
    logic miss_ld_i = 1'b0;
    logic abort_i = 1'b0;
    logic stall = 1'b0;
    miss_t miss_i = '0;
    logic [3:0] miss_ld_id_i = 4'h0;
    logic [3:0] abort_id_i = 4'h0;
    areq_t ac = '0, tc = '0, ld = '0, st = '0, pr = '0;
    own_t tag_own [2];
    own_t data_own [2];
    logic miss_rdy_o, fill_we_o, fwd_vld_o, sc_rd_o, sc_rdy_o, sc_vld_i;
    fill_t fill_o;
    miss_t sc_req_o;
    logic [`WAIT_N-1:0] fwd_mask_o;
    logic [`QW_W-1:0] fwd_data_o, sc_data_i;
    miss_t exp_q[$];
    int fail_count = 0, compares = 0, cyc = 0, t0 = 0, cur = 0;
    int seed = 32'h7048_eba9;
    logic [1:0] bcnt = 2'h0;
    logic rdy_q = 1'b0, chk_rel = 1'b0, hit5 = 1'b0;

    // Core clock, and a link clock with an unrelated phase
    always #12.5 core_clk_i = ~core_clk_i;
    initial begin
        #3.7;
        forever #6 sc_clk_i = ~sc_clk_i;
    end

    primary_cache_refill_engine primary_cache_refill_engine_i (
        .core_clk_i, .sys_rst_i, .sc_clk_i,
        .secondary_clock_divisor_mode_i(md),
        .miss_vld_i, .miss_i, .miss_ld_i, .miss_ld_id_i, .miss_rdy_o,
        .abort_i, .abort_id_i,
        .ac_req_i(ac), .tc_req_i(tc), .ld_req_i(ld), .st_req_i(st),
        .ext_probe_i(pr), .tag_own_o(tag_own), .data_own_o(data_own),
        .fill_we_o, .fill_o, .fwd_vld_o, .fwd_mask_o, .fwd_data_o,
        .sc_rd_o, .sc_req_o, .sc_rdy_o, .sc_vld_i, .sc_data_i
    );

    sc_agent sc_agent_i (
        .sc_clk_i, .stall_i(stall), .rd_i(sc_rd_o), .req_i(sc_req_o),
        .rdy_i(sc_rdy_o), .vld_o(sc_vld_i), .data_o(sc_data_i)
    );

    task automatic wrap_up();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Hang guard, well above the length of the whole sequence
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fail_count++;
            wrap_up();
        end
    end

    // Shortest span from first to last beat of a line, by divisor mode
    function automatic int min_span(input logic ic);
        if (ic) begin
            return (md == MODE_1) ? 3 : (md == MODE_1P5) ? 4 : 6;
        end
        return (md == MODE_2) ? 2 : 1;
    endfunction

    // Owner expected from the requests held during the last cycle
    function automatic own_t exp_own(input logic b, input logic dat);
        if (pr.vld && pr.bank == b) return OWN_EXT;
        if (!dat && tc.vld && tc.bank == b) return OWN_TC;
        if (!dat && ac.vld && ac.bank == b) return OWN_AC;
        if (dat && ld.vld && ld.bank == b) return OWN_LD;
        if (dat && st.vld && st.bank == b) return OWN_ST;
        return OWN_NONE;
    endfunction

    function automatic miss_t rnd_miss(input logic ic);
        miss_t m;
        m.addr = $random(seed);
        m.icache = ic;
        return m;
    endfunction

    // Each written quadword must be the next one of its line, found in the queue at its first beat
    always @(negedge core_clk_i) begin
        if (!sys_rst_i && fill_we_o) begin
            // Slots issue lowest first, so lines may land out of order
            if (bcnt == 2'h0) begin
                cur = 0;
                t0 = cyc;
                foreach (exp_q[i]) begin
                    if (exp_q[i] === fill_o.m) cur = i;
                end
            end
            `CHK(fill_o.m, exp_q[cur])
            `CHK(fill_o.idx, bcnt)
            `CHK(fill_o.data, {exp_q[cur].addr, 94'h0, bcnt})
            if (bcnt == (exp_q[cur].icache ? 2'h3 : 2'h1)) begin
                `CHK(cyc - t0 >= min_span(exp_q[cur].icache), 1'b1)
                exp_q.delete(cur);
                bcnt = 2'h0;
            end else begin
                bcnt = bcnt + 2'h1;
            end
        end
        if (fwd_vld_o) begin
            `CHK(fwd_data_o, fill_o.data)
            hit5 = hit5 | fwd_mask_o[5];
        end
        // A slot frees only with the last beat of its line
        if (chk_rel && miss_rdy_o && !rdy_q) begin
            `CHK(fill_we_o && fill_o.idx == 2'h3, 1'b1)
        end
        rdy_q = miss_rdy_o;
    end

    // Hold a miss until it is taken; the caller lowers the request
    task automatic send(input miss_t m, input logic w, input logic [3:0] id);
        miss_vld_i = 1'b1;
        miss_i = m;
        miss_ld_i = w;
        miss_ld_id_i = id;
        while (!miss_rdy_o) @(negedge core_clk_i);
        @(negedge core_clk_i);
        exp_q.push_back(m);
    endtask

    task automatic drain();
        miss_vld_i = 1'b0;
        while (exp_q.size() != 0) @(negedge core_clk_i);
        repeat (10) @(negedge core_clk_i);
    endtask

    // Latency from miss taken to the waited word reaching its load
    task automatic lat_test(input miss_t m, input int lo);
        int t;
        send(m, 1'b1, 4'h3);
        t = cyc;
        miss_vld_i = 1'b0;
        while (!fwd_vld_o) @(negedge core_clk_i);
        `CHK(cyc - t >= lo && cyc - t < 80, 1'b1)
        `CHK(fwd_mask_o[3], 1'b1)
        `CHK(fwd_data_o[1:0], {1'b0, m.addr[4]})
        drain();
    endtask

    initial begin
        repeat (12) @(negedge core_clk_i);
        sys_rst_i = 1'b0;
        repeat (2) @(negedge core_clk_i);
        // Each mode: latency, then a random back-to-back burst
        for (int k = 0; k < 3; k++) begin
            md = mode_t'(k);
            lat_test(rnd_miss(1'b0), k == 0 ? 6 : k == 1 ? 8 : 9);
            for (int j = 0; j < 6; j++) begin
                send(rnd_miss($random(seed) & 1), 1'b0, 4'h0);
            end
            drain();
        end
        // Aborted waiter: the line still lands, nothing goes to it
        hit5 = 1'b0;
        send(rnd_miss(1'b0), 1'b1, 4'h5);
        miss_vld_i = 1'b0;
        abort_i = 1'b1;
        abort_id_i = 4'h5;
        @(negedge core_clk_i);
        abort_i = 1'b0;
        drain();
        `CHK(hit5, 1'b0)
        // Four lines outstanding behind a stalled link; a fifth waits
        stall = 1'b1;
        chk_rel = 1'b1;
        for (int j = 0; j < 4; j++) send(rnd_miss(1'b1), 1'b0, 4'h0);
        for (int j = 0; j < 20; j++) begin
            `CHK(miss_rdy_o, 1'b0)
            @(negedge core_clk_i);
        end
        stall = 1'b0;
        send(rnd_miss(1'b1), 1'b0, 4'h0);
        drain();
        chk_rel = 1'b0;
        // Random array requests; cycles with a refill write are skipped
        send(rnd_miss(1'b0), 1'b0, 4'h0);
        miss_vld_i = 1'b0;
        for (int j = 0; j < 400; j++) begin
            for (int b = 0; b < 2; b++) begin
                if (!fill_we_o) begin
                    `CHK(tag_own[b], exp_own(b[0], 1'b0))
                    `CHK(data_own[b], exp_own(b[0], 1'b1))
                end
            end
            {ac, tc, ld, st, pr} = 10'($random(seed));
            @(negedge core_clk_i);
        end
        drain();
        wrap_up();
    end
endmodule // tb
